// *** rtiu_pkg.sv ***
// Constants, types and decode helpers for the return instruction unit
// Function
// RL1: Irq return pops the stack into the pc; one word, two cycles.
// RL2: Irq return sets the high or low priority global enable only.
// RL3: Fast bit 1 restores accumulator, flags and bank select shadows.
// RL4: Fast bit 0 leaves accumulator, flags and bank select unchanged.
// RL5: Literal return (upper byte 0000 1100) loads its literal into acc.
// RL6: Literal return pops the stack into the pc in Q4 of cycle one.
// RL7: No return touches the program counter high and upper latches.
// RL8: Subroutine return (0000 0000 0001 001s) pops the stack, two cycles.
// RL9: The second cycle of every return is a no-op flushing the prefetch.
package rtiu_pkg;
   localparam int PC_W  = 21;
   localparam int ACC_W = 8;
   localparam int FLG_W = 5;
   localparam int BSR_W = 4;
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int PH_N  = 4;

   // Phase positions within one instruction cycle
   localparam int PH_Q1 = 0;
   localparam int PH_Q4 = 3;

   // Opcode fields
   localparam logic [14:0] OPC_IRQ_RET = 15'h0008;
   localparam logic [14:0] OPC_SUB_RET = 15'h0009;
   localparam logic [7:0]  OPC_LIT_RET = 8'h0c;

   // Register offsets
   localparam logic [ADR_W-1:0] OFS_CTRL  = 8'h00;
   localparam logic [ADR_W-1:0] OFS_ACC   = 8'h04;
   localparam logic [ADR_W-1:0] OFS_FLG   = 8'h08;
   localparam logic [ADR_W-1:0] OFS_BSR   = 8'h0c;
   localparam logic [ADR_W-1:0] OFS_PCH   = 8'h10;
   localparam logic [ADR_W-1:0] OFS_PCU   = 8'h14;
   localparam logic [ADR_W-1:0] OFS_IEN   = 8'h18;
   localparam logic [ADR_W-1:0] OFS_PC    = 8'h1c;
   localparam logic [ADR_W-1:0] OFS_STATE = 8'h20;

   // Field positions
   localparam int CTRL_PRIO = 0;
   localparam int IEN_HIGH  = 0;
   localparam int IEN_LOW   = 1;
   localparam int ST_BUSY   = 0;
   localparam int ST_FLUSH  = 1;
   localparam int ST_PH     = 4;

   // Reset values
   localparam logic [PC_W-1:0] RST_PC = 21'h000000;
   localparam logic [7:0]      RST_8  = 8'h00;

   typedef enum logic [2:0] {
      RTIU_IDLE  = 3'b001,
      RTIU_EXEC  = 3'b010,
      RTIU_FLUSH = 3'b100
   } rtiu_state_t;

   function automatic logic rtiu_is_irq_ret(input logic [15:0] w);
      return w[15:1] == OPC_IRQ_RET;
   endfunction

   function automatic logic rtiu_is_sub_ret(input logic [15:0] w);
      return w[15:1] == OPC_SUB_RET;
   endfunction

   function automatic logic rtiu_is_lit_ret(input logic [15:0] w);
      return w[15:8] == OPC_LIT_RET;
   endfunction

   function automatic logic [DAT_W-1:0] rtiu_zext(input logic [PC_W-1:0] v);
      return {{(DAT_W-PC_W){1'b0}}, v};
   endfunction
endpackage

// *** rtiu_phase.sv ***
// Four-phase sequencer for the instruction cycle
module rtiu_phase
   import rtiu_pkg::*;
#(
   parameter int N = PH_N
) (
   input  wire logic         core_clk,
   input  wire logic         arst_n,
   input  wire logic         clk_en,
   output logic [N-1:0]      phase
);
   logic [N-1:0] next_phase;

   always_comb begin
      next_phase = {phase[N-2:0], phase[N-1]};
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase <= N'(1);
      end else if (clk_en) begin
         phase <= next_phase;
      end
   end
endmodule // rtiu_phase

// *** rtiu_return_unit.sv ***
// Return instruction execution unit with its register port
module rtiu_return_unit
   import rtiu_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   input  wire logic             clk_en,
   input  wire logic [15:0]      instr_word,
   input  wire logic             instr_valid,
   input  wire logic [PC_W-1:0]  stack_top,
   input  wire logic [ACC_W-1:0] accumulator_shadow,
   input  wire logic [FLG_W-1:0] flags_shadow,
   input  wire logic [BSR_W-1:0] bank_select_shadow,
   input  wire logic             in_high_isr,
   input  wire logic [ADR_W-1:0] reg_addr,
   input  wire logic [DAT_W-1:0] reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [DAT_W-1:0]      reg_rdata,
   output logic [PC_W-1:0]       prog_counter,
   output logic [ACC_W-1:0]      accumulator,
   output logic [FLG_W-1:0]      flags,
   output logic [BSR_W-1:0]      bank_select_reg,
   output logic [7:0]            prog_counter_high_latch,
   output logic [7:0]            prog_counter_upper_latch,
   output logic                  high_prio_global_irq_en,
   output logic                  low_prio_global_irq_en,
   output logic                  stack_pop,
   output logic                  fetch_flush,
   output logic                  busy
);
   logic [PH_N-1:0] phase;
   rtiu_state_t     state;
   rtiu_state_t     next_state;
   logic            op_irq;
   logic            op_lit;
   logic            fast;
   logic [7:0]      literal;
   logic            next_op_irq;
   logic            next_op_lit;
   logic            next_fast;
   logic [7:0]      next_literal;
   logic            start;
   logic            exec_end;
   logic            prio_en;
   logic            next_prio_en;
   logic [PC_W-1:0]  next_prog_counter;
   logic [ACC_W-1:0] next_accumulator;
   logic [FLG_W-1:0] next_flags;
   logic [BSR_W-1:0] next_bank_select_reg;
   logic [7:0]       next_pch;
   logic [7:0]       next_pcu;
   logic             next_high_en;
   logic             next_low_en;
   logic             next_stack_pop;
   logic             next_fetch_flush;
   logic             next_busy;
   logic [DAT_W-1:0] next_reg_rdata;

   rtiu_phase #(.N(PH_N)) u_phase (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clk_en   (clk_en),
      .phase    (phase)
   );

   // Decode in Q1, one-word instructions only
   assign start = (state == RTIU_IDLE) && phase[PH_Q1] && instr_valid &&
                  (rtiu_is_irq_ret(instr_word) ||
                   rtiu_is_sub_ret(instr_word) ||
                   rtiu_is_lit_ret(instr_word));
   assign exec_end = (state == RTIU_EXEC) && phase[PH_Q4];

   // Sequencer group
   always_comb begin
      next_state   = state;
      next_op_irq  = op_irq;
      next_op_lit  = op_lit;
      next_fast    = fast;
      next_literal = literal;
      case (state)
         RTIU_IDLE: begin
            if (start) begin
               next_state   = RTIU_EXEC;
               next_op_irq  = rtiu_is_irq_ret(instr_word);
               next_op_lit  = rtiu_is_lit_ret(instr_word);
               next_fast    = !rtiu_is_lit_ret(instr_word) && instr_word[0];
               next_literal = instr_word[7:0];
            end
         end
         RTIU_EXEC: begin
            if (phase[PH_Q4]) begin
               next_state = RTIU_FLUSH; // see RL8
            end
         end
         RTIU_FLUSH: begin
            if (phase[PH_Q4]) begin
               next_state = RTIU_IDLE; // see RL9
            end
         end
         default: begin
            next_state = RTIU_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state   <= RTIU_IDLE;
         op_irq  <= 1'b0;
         op_lit  <= 1'b0;
         fast    <= 1'b0;
         literal <= RST_8;
      end else if (clk_en) begin
         state   <= next_state;
         op_irq  <= next_op_irq;
         op_lit  <= next_op_lit;
         fast    <= next_fast;
         literal <= next_literal;
      end
   end

   // Architectural registers and register port
   always_comb begin
      next_prog_counter    = prog_counter;
      next_accumulator     = accumulator; // see RL4
      next_flags           = flags;
      next_bank_select_reg = bank_select_reg;
      next_pch             = prog_counter_high_latch;
      next_pcu             = prog_counter_upper_latch;
      next_high_en         = high_prio_global_irq_en;
      next_low_en          = low_prio_global_irq_en;
      next_prio_en         = prio_en;
      next_reg_rdata       = '0;
      if (reg_wr) begin
         case (reg_addr)
            OFS_CTRL: next_prio_en = reg_wdata[CTRL_PRIO];
            OFS_ACC:  next_accumulator = reg_wdata[ACC_W-1:0];
            OFS_FLG:  next_flags = reg_wdata[FLG_W-1:0];
            OFS_BSR:  next_bank_select_reg = reg_wdata[BSR_W-1:0];
            OFS_PCH:  next_pch = reg_wdata[7:0];
            OFS_PCU:  next_pcu = reg_wdata[7:0];
            OFS_IEN: begin
               next_high_en = reg_wdata[IEN_HIGH];
               next_low_en  = reg_wdata[IEN_LOW];
            end
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            OFS_CTRL:  next_reg_rdata[CTRL_PRIO] = prio_en;
            OFS_ACC:   next_reg_rdata[ACC_W-1:0] = accumulator;
            OFS_FLG:   next_reg_rdata[FLG_W-1:0] = flags;
            OFS_BSR:   next_reg_rdata[BSR_W-1:0] = bank_select_reg;
            OFS_PCH:   next_reg_rdata[7:0] = prog_counter_high_latch;
            OFS_PCU:   next_reg_rdata[7:0] = prog_counter_upper_latch;
            OFS_IEN: begin
               next_reg_rdata[IEN_HIGH] = high_prio_global_irq_en;
               next_reg_rdata[IEN_LOW]  = low_prio_global_irq_en;
            end
            OFS_PC:    next_reg_rdata = rtiu_zext(prog_counter);
            OFS_STATE: begin
               next_reg_rdata[ST_BUSY]  = busy;
               next_reg_rdata[ST_FLUSH] = fetch_flush;
               next_reg_rdata[ST_PH +: PH_N] = phase;
            end
            default: next_reg_rdata = '0;
         endcase
      end
      // Instruction effects win over a bus write in the same clock
      if (exec_end) begin
         next_prog_counter = stack_top; // see RL1 see RL6 see RL8
         if (op_lit) begin
            next_accumulator = literal; // see RL5
         end else if (fast) begin
            next_accumulator     = accumulator_shadow; // see RL3
            next_flags           = flags_shadow; // see RL3
            next_bank_select_reg = bank_select_shadow; // see RL3
         end
         if (op_irq) begin
            if (!prio_en || in_high_isr) begin
               next_high_en = 1'b1; // see RL2
            end else begin
               next_low_en = 1'b1; // see RL2
            end
         end
      end
   end

   assign next_stack_pop   = exec_end; // see RL1 see RL6
   assign next_fetch_flush = (next_state == RTIU_FLUSH); // see RL9
   assign next_busy        = (next_state != RTIU_IDLE);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prog_counter             <= RST_PC;
         accumulator              <= '0;
         flags                    <= '0;
         bank_select_reg          <= '0;
         prog_counter_high_latch  <= RST_8;
         prog_counter_upper_latch <= RST_8;
         high_prio_global_irq_en  <= 1'b0;
         low_prio_global_irq_en   <= 1'b0;
         prio_en                  <= 1'b0;
         stack_pop                <= 1'b0;
         fetch_flush              <= 1'b0;
         busy                     <= 1'b0;
         reg_rdata                <= '0;
      end else if (clk_en) begin
         prog_counter             <= next_prog_counter;
         accumulator              <= next_accumulator;
         flags                    <= next_flags;
         bank_select_reg          <= next_bank_select_reg;
         prog_counter_high_latch  <= next_pch; // see RL7
         prog_counter_upper_latch <= next_pcu; // see RL7
         high_prio_global_irq_en  <= next_high_en;
         low_prio_global_irq_en   <= next_low_en;
         prio_en                  <= next_prio_en;
         stack_pop                <= next_stack_pop;
         fetch_flush              <= next_fetch_flush;
         busy                     <= next_busy;
         reg_rdata                <= next_reg_rdata;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk iff clk_en);
   endclocking
   default disable iff (!arst_n);

   sequence s_exec_end;
      state == RTIU_EXEC && phase[PH_Q4];
   endsequence

   sequence s_no_op_cycle;
      fetch_flush [*4] ##1 !busy;
   endsequence

   property p_pop_pc;
      s_exec_end |=> stack_pop && prog_counter == $past(stack_top);
   endproperty
   a_pop_pc: assert property (p_pop_pc) // see RL1
      else $error("stack pop or pc load missing");

   property p_irq_en;
      s_exec_end ##0 op_irq |=>
         ((!$past(prio_en) || $past(in_high_isr)) ?
          high_prio_global_irq_en : low_prio_global_irq_en);
   endproperty
   a_irq_en: assert property (p_irq_en) // see RL2
      else $error("global enable not set on irq return");

   property p_no_irq_en;
      s_exec_end ##0 (!op_irq && !reg_wr) |=>
         $stable(high_prio_global_irq_en) && $stable(low_prio_global_irq_en);
   endproperty
   a_no_irq_en: assert property (p_no_irq_en) // see RL8
      else $error("enable changed by non-irq return");

   property p_fast;
      s_exec_end ##0 (fast && !op_lit) |=>
         accumulator == $past(accumulator_shadow) &&
         flags == $past(flags_shadow) &&
         bank_select_reg == $past(bank_select_shadow);
   endproperty
   a_fast: assert property (p_fast) // see RL3
      else $error("shadow restore missing");

   property p_keep;
      s_exec_end ##0 (!fast && !op_lit && !reg_wr) |=>
         $stable(accumulator) && $stable(flags) && $stable(bank_select_reg);
   endproperty
   a_keep: assert property (p_keep) // see RL4
      else $error("working registers changed without fast return");

   property p_lit;
      s_exec_end ##0 op_lit |=> accumulator == $past(literal);
   endproperty
   a_lit: assert property (p_lit) // see RL5
      else $error("literal not written to accumulator");

   property p_latch;
      busy && !reg_wr |=>
         $stable(prog_counter_high_latch) && $stable(prog_counter_upper_latch);
   endproperty
   a_latch: assert property (p_latch) // see RL7
      else $error("pc latch changed by return");

   property p_two_cycles;
      start |=> (state == RTIU_EXEC) [*3] ##1 (state == RTIU_FLUSH);
   endproperty
   a_two_cycles: assert property (p_two_cycles) // see RL8
      else $error("return did not take two cycles");

   property p_flush;
      s_exec_end |=> s_no_op_cycle;
   endproperty
   a_flush: assert property (p_flush) // see RL9
      else $error("second cycle not a flush");

   property p_lit_timing;
      start ##0 rtiu_is_lit_ret(instr_word) |-> ##3 s_exec_end ##1 stack_pop;
   endproperty
   a_lit_timing: assert property (p_lit_timing) // see RL6
      else $error("literal return pop not at end of first cycle");
endmodule // rtiu_return_unit

// *** return_instruction_unit_tb.sv ***
// Self-checking testbench for the return instruction unit
module return_instruction_unit_tb
   import rtiu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic             core_clk = 0, arst_n = 0, clk_en = 1;
   logic             instr_valid = 0, in_high_isr = 0;
   logic [15:0]      instr_word = 0;
   logic [PC_W-1:0]  stack_top = 0;
   logic [ACC_W-1:0] accumulator_shadow = 0, accumulator;
   logic [FLG_W-1:0] flags_shadow = 0, flags;
   logic [BSR_W-1:0] bank_select_shadow = 0, bank_select_reg;
   logic [ADR_W-1:0] reg_addr = 0;
   logic [DAT_W-1:0] reg_wdata = 0, reg_rdata;
   logic             reg_wr = 0, reg_rd = 0, stack_pop, fetch_flush, busy;
   logic [PC_W-1:0]  prog_counter;
   logic [7:0]       prog_counter_high_latch, prog_counter_upper_latch;
   logic             high_prio_global_irq_en, low_prio_global_irq_en;
   logic [1:0]       ph = 0;
   int               error_cnt = 0, n_checks = 0, cycles = 0;
   int               m_pc, m_acc, m_flg, m_bsr, m_pch, m_pcu, m_ien;

   rtiu_return_unit dut (
      .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
      .instr_word(instr_word), .instr_valid(instr_valid),
      .stack_top(stack_top), .accumulator_shadow(accumulator_shadow),
      .flags_shadow(flags_shadow), .bank_select_shadow(bank_select_shadow),
      .in_high_isr(in_high_isr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .prog_counter(prog_counter), .accumulator(accumulator), .flags(flags),
      .bank_select_reg(bank_select_reg),
      .prog_counter_high_latch(prog_counter_high_latch),
      .prog_counter_upper_latch(prog_counter_upper_latch),
      .high_prio_global_irq_en(high_prio_global_irq_en),
      .low_prio_global_irq_en(low_prio_global_irq_en),
      .stack_pop(stack_pop), .fetch_flush(fetch_flush), .busy(busy));

   always #25 core_clk = ~core_clk;

   // Phase count, Q1 at the first edge after release
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) ph <= 2'h0;
      else if (clk_en) ph <= ph + 2'h1;
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
      @(posedge core_clk);
      #1 chk(reg_rdata, 32'h0);
   endtask

   task automatic chk_regs();
      chk(prog_counter, m_pc);
      chk(accumulator, m_acc);
      chk(flags, m_flg);
      chk(bank_select_reg, m_bsr);
      chk(prog_counter_high_latch, m_pch);
      chk(prog_counter_upper_latch, m_pcu);
      chk({low_prio_global_irq_en, high_prio_global_irq_en}, m_ien);
   endtask

   // One return of kind k (0 irq, 1 subroutine, 2 literal)
   task automatic run_ret(input int k, input logic s, input logic prio);
      logic [7:0] lit;
      lit = 8'($urandom);
      do @(posedge core_clk); while (ph != 2'h3);
      instr_valid <= 1'b1;
      instr_word <= (k == 0) ? {15'h0008, s} :
                    (k == 1) ? {15'h0009, s} : {8'h0c, lit};
      @(posedge core_clk);
      instr_word <= {8'h0c, ~lit};
      m_pc = stack_top;
      if (k == 2) m_acc = lit;
      else if (s) begin
         m_acc = accumulator_shadow;
         m_flg = flags_shadow;
         m_bsr = bank_select_shadow;
      end
      if (k == 0) m_ien = m_ien | ((!prio || in_high_isr) ? 1 : 2);
      #1 chk(busy, 1'b1);
      repeat (2) @(posedge core_clk);
      #1 chk({stack_pop, prog_counter == m_pc}, 2'b00);
      @(posedge core_clk);
      #1 chk({stack_pop, fetch_flush}, 2'b11);
      chk_regs();
      @(posedge core_clk);
      instr_valid <= 1'b0;
      #1 chk({stack_pop, fetch_flush}, 2'b01);
      repeat (3) @(posedge core_clk);
      #1 chk({busy, fetch_flush}, 2'b00);
      chk_regs();
      rd(OFS_ACC, m_acc);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      logic prio;
      void'($urandom(17307));
      m_pc = 0; m_acc = 0; m_flg = 0; m_bsr = 0;
      m_pch = 0; m_pcu = 0; m_ien = 0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      #1 chk_regs();
      rd(8'h24, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 30; i++) begin
         prio = 1'($urandom);
         m_acc = $urandom % 256;
         m_flg = $urandom % 32;
         m_bsr = $urandom % 16;
         m_pch = $urandom % 256;
         m_pcu = $urandom % 256;
         m_ien = 0;
         wr(OFS_CTRL, {31'h0, prio});
         wr(OFS_ACC, m_acc);
         wr(OFS_FLG, m_flg);
         wr(OFS_BSR, m_bsr);
         wr(OFS_PCH, m_pch);
         wr(OFS_PCU, m_pcu);
         wr(OFS_IEN, 32'h0);
         @(posedge core_clk);
         stack_top <= PC_W'($urandom);
         accumulator_shadow <= 8'($urandom);
         flags_shadow <= 5'($urandom);
         bank_select_shadow <= 4'($urandom);
         in_high_isr <= 1'($urandom);
         run_ret(i % 3, 1'((i / 3) % 2), prio);
      end
      $display("return test done");
      wr(OFS_PC, 32'h0);
      rd(OFS_PC, m_pc);
      wr(8'h24, 32'hff);
      rd(8'h24, 32'h0);
      $display("register test done");
      @(posedge core_clk);
      clk_en <= 1'b0;
      wr(OFS_ACC, ~m_acc);
      repeat (3) @(posedge core_clk);
      clk_en <= 1'b1;
      #1 chk_regs();
      rd(OFS_STATE, 32'h10 << (ph + 2'h1));
      $display("clock enable test done");
      end_sim();
   end
endmodule // return_instruction_unit_tb
